// [hw/fsbp_pkg.sv]
// package of the protection block, then the protected-area decoder
// assumes the main file instantiates fsbp_area_decode once
`timescale 1ns/10ps
package fsbp_pkg;
    // =====================================================
    // status register layout
    localparam int SR_WIDTH         = 8;
    localparam int SR_LOCK_BIT      = 7;
    localparam int SR_BP_MSB_BIT    = 6;
    localparam int SR_TB_BIT        = 5;
    localparam int SR_BP_LOW_HI     = 4;
    localparam int SR_BP_LOW_LO     = 2;
    localparam int SR_WEL_BIT       = 1;
    localparam int SR_WIP_BIT       = 0;
    localparam int FSR_READY_BIT    = 7;
    localparam int BP_WIDTH         = 4;
    localparam logic [3:0] BP_NONE  = 4'h0;
    localparam logic [3:0] BP_ALL   = 4'ha;
    // =====================================================
    // array map
    localparam int ADDR_WIDTH       = 25;
    localparam logic [24:0] ADDR_MAX = 25'h1ffffff;
    localparam int SECTOR_WIDTH     = 9;
    localparam int SECTOR_LSB       = 16;
    localparam int SUB32_LSB        = 15;
    localparam int SUB4_LSB         = 12;
    localparam logic [9:0] SECTOR_COUNT = 10'h200;
    localparam logic [9:0] ONE_SECTOR   = 10'h001;
    // =====================================================
    // timing: busy counter width in bits, core clock period in ns
    localparam int CNT_WIDTH        = 16;
    localparam int CLK_PERIOD_NS    = 10;
    // =====================================================
    // types
    typedef enum logic [3:0] {
        FSBP_NOP    = 4'h0,
        FSBP_WREN   = 4'h1,
        FSBP_WRDI   = 4'h2,
        FSBP_WRSR   = 4'h3,
        FSBP_PROG   = 4'h4,
        FSBP_SE64   = 4'h5,
        FSBP_SE32   = 4'h6,
        FSBP_SE4    = 4'h7,
        FSBP_BULK   = 4'h8,
        FSBP_RDSR   = 4'h9,
        FSBP_WRNVCR = 4'ha
    } fsbp_cmd_t;

    typedef enum logic [1:0] {
        FSBP_IDLE = 2'b00,
        FSBP_BUSY = 2'b01
    } fsbp_state_t;

    typedef struct packed {
        fsbp_cmd_t         cmd;
        logic [24:0]       addr;
        logic [7:0]        data;
    } fsbp_req_t;

    typedef struct packed {
        logic [7:0]        status;
        logic              accepted;
        logic              prot_err;
    } fsbp_rsp_t;
endpackage

// =====================================================
// protected-area decoder, purely combinational
module fsbp_area_decode (
    input  wire logic [3:0] block_protect_field_in,
    input  wire logic       bottom_in,
    input  wire logic [8:0] sector_in,
    output logic            hit_out
);
    logic [9:0] span;
    logic [9:0] sect;

    always_comb begin
        sect = {1'b0, sector_in};
        if (block_protect_field_in == fsbp_pkg::BP_NONE) begin
            span = 10'h000;
        end else if (block_protect_field_in >= fsbp_pkg::BP_ALL) begin
            span = fsbp_pkg::SECTOR_COUNT;
        end else begin
            span = fsbp_pkg::ONE_SECTOR << (block_protect_field_in - 4'h1);
        end
        if (bottom_in) begin
            hit_out = sect < span;
        end else begin
            hit_out = sect >= (fsbp_pkg::SECTOR_COUNT - span);
        end
    end
endmodule

// [hw/fsbp_status_ctrl.sv]
// status register and block protection of a serial nor flash
// assumes link-side commands arrive on link_clk_in, already decoded
//
// Function
// - lock bit set and write-protect low: status writes are refused
// - only raising the write-protect input or a reset lifts the hardware lock
// - bit 7 is the status write lock, default zero
// - bit 5 picks top or bottom for the protected area, default top
// - bits 6 and 4:2 hold block protect; protected area rejects program and erase
// - write enable latch clear at reset; set by write enable before writes
// - bit 0 busy during status write, config write, program, erase
// - busy bit always the inverse of the flag ready bit
// - bulk erase runs only with all block protect bits zero
// - top: value n protects highest 2^(n-1) sectors, 10 up protects all
// - bottom: value n protects lowest 2^(n-1) sectors, 10 up protects all
// - array is 512 sectors of 64KB, subsectors 32KB and 4KB
// - write-protect input sampled as a level, always driven
`timescale 1ns/10ps
module fsbp_status_ctrl #(
    parameter int WRSR_CYCLES  = 16,
    parameter int PROG_CYCLES  = 32,
    parameter int ERASE_CYCLES = 64,
    parameter int BULK_CYCLES  = 128
) (
    input  wire logic                clock_in,
    input  wire logic                reset_n_in,
    input  wire logic                link_clk_in,
    input  wire logic                write_protect_n_in,
    input  wire logic                cmd_valid_in,
    input  wire fsbp_pkg::fsbp_req_t cmd_in,
    output logic                     cmd_ready_out,
    output logic                     rsp_valid_out,
    output fsbp_pkg::fsbp_rsp_t      rsp_out,
    output logic [7:0]               status_out,
    output logic                     flag_ready_out,
    output logic                     op_start_out,
    output fsbp_pkg::fsbp_cmd_t      op_code_out,
    output logic [24:0]              op_addr_out
);
    // =====================================================
    // helpers
    function automatic logic [7:0] status_byte(input logic lock, input logic tb,
                                               input logic [3:0] bp, input logic wel,
                                               input logic wip);
        logic [7:0] s;
        s = 8'h00;
        s[fsbp_pkg::SR_LOCK_BIT]   = lock;
        s[fsbp_pkg::SR_TB_BIT]     = tb;
        s[fsbp_pkg::SR_BP_MSB_BIT] = bp[3];
        s[fsbp_pkg::SR_BP_LOW_HI:fsbp_pkg::SR_BP_LOW_LO] = bp[2:0];
        s[fsbp_pkg::SR_WEL_BIT]    = wel;
        s[fsbp_pkg::SR_WIP_BIT]    = wip;
        return s;
    endfunction

    function automatic logic [24:0] align(input logic [24:0] a, input int lsb);
        logic [24:0] m;
        m = ~((25'h0000001 << lsb) - 25'h0000001);
        return a & m;
    endfunction

    // =====================================================
    // link domain: request capture and answer
    logic                rst_meta_reg, rst_sync_reg;
    fsbp_pkg::fsbp_req_t hold_reg, hold_next;
    logic                req_tog_reg, req_tog_next;
    logic                ready_reg, ready_next;
    logic                ack_m_reg, ack_s_reg, ack_d_reg;
    logic                rvalid_reg, rvalid_next;
    fsbp_pkg::fsbp_rsp_t rsp_lnk_reg, rsp_lnk_next;
    logic                ack_tog_reg;
    fsbp_pkg::fsbp_rsp_t rsp_core_reg;

    always_ff @(posedge link_clk_in) begin
        rst_meta_reg <= reset_n_in;
        rst_sync_reg <= rst_meta_reg;
    end

    always_comb begin
        hold_next    = hold_reg;
        req_tog_next = req_tog_reg;
        ready_next   = ready_reg;
        rvalid_next  = 1'b0;
        rsp_lnk_next = rsp_lnk_reg;
        // nothing outstanding: open for a request, also after reset
        if (!ready_reg && req_tog_reg == ack_d_reg && ack_s_reg == ack_d_reg) begin
            ready_next = 1'b1;
        end
        if (cmd_valid_in && ready_reg) begin
            hold_next    = cmd_in;
            req_tog_next = ~req_tog_reg;
            ready_next   = 1'b0;
        end
        if (ack_s_reg != ack_d_reg) begin
            rvalid_next  = 1'b1;
            rsp_lnk_next = rsp_core_reg;
            ready_next   = 1'b1;
        end
    end

    always_ff @(posedge link_clk_in) begin
        if (!rst_sync_reg) begin
            hold_reg    <= '0;
            req_tog_reg <= 1'b0;
            ready_reg   <= 1'b0;
            ack_m_reg   <= 1'b0;
            ack_s_reg   <= 1'b0;
            ack_d_reg   <= 1'b0;
            rvalid_reg  <= 1'b0;
            rsp_lnk_reg <= '0;
        end else begin
            hold_reg    <= hold_next;
            req_tog_reg <= req_tog_next;
            ready_reg   <= ready_next;
            ack_m_reg   <= ack_tog_reg;
            ack_s_reg   <= ack_m_reg;
            ack_d_reg   <= ack_s_reg;
            rvalid_reg  <= rvalid_next;
            rsp_lnk_reg <= rsp_lnk_next;
        end
    end

    assign cmd_ready_out = ready_reg;
    assign rsp_valid_out = rvalid_reg;
    assign rsp_out       = rsp_lnk_reg;

    // =====================================================
    // core domain: synchronisers
    logic req_m_reg, req_s_reg, req_d_reg;
    logic wp_m_reg, wp_level_reg;
    logic req_new;

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            req_m_reg    <= 1'b0;
            req_s_reg    <= 1'b0;
            req_d_reg    <= 1'b0;
            wp_m_reg     <= 1'b0;
            wp_level_reg <= 1'b0;
        end else begin
            req_m_reg    <= req_tog_reg;
            req_s_reg    <= req_m_reg;
            req_d_reg    <= req_s_reg;
            wp_m_reg     <= write_protect_n_in;
            wp_level_reg <= wp_m_reg;
        end
    end
    assign req_new = req_s_reg != req_d_reg;

    // =====================================================
    // core domain: status, protection and busy timing
    fsbp_pkg::fsbp_state_t st_reg, st_next;
    logic [15:0]         cnt_reg, cnt_next;
    logic                lock_reg, lock_next, tb_reg, tb_next;
    logic [3:0]          bp_reg, bp_next;
    logic                wel_reg, wel_next, wip_reg, ready_f_reg;
    logic                ack_tog_next;
    fsbp_pkg::fsbp_rsp_t rsp_core_next;
    logic [7:0]          sr_reg;
    logic                start_reg, start_next;
    fsbp_pkg::fsbp_cmd_t code_reg, code_next;
    logic [24:0]         addr_reg, addr_next;
    logic                prot_hit;
    logic                hw_locked;

    fsbp_area_decode u_area (
        .block_protect_field_in (bp_reg),
        .bottom_in              (tb_reg),
        .sector_in              (hold_reg.addr[fsbp_pkg::ADDR_WIDTH-1:fsbp_pkg::SECTOR_LSB]),
        .hit_out                (prot_hit)
    );

    assign hw_locked = lock_reg && !wp_level_reg;

    always_comb begin
        st_next       = st_reg;
        cnt_next      = cnt_reg;
        lock_next     = lock_reg;
        tb_next       = tb_reg;
        bp_next       = bp_reg;
        wel_next      = wel_reg;
        ack_tog_next  = ack_tog_reg;
        rsp_core_next = rsp_core_reg;
        start_next    = 1'b0;
        code_next     = code_reg;
        addr_next     = addr_reg;
        case (st_reg)
            fsbp_pkg::FSBP_IDLE: begin
            end
            fsbp_pkg::FSBP_BUSY: begin
                if (cnt_reg == 16'h0000) begin
                    st_next  = fsbp_pkg::FSBP_IDLE;
                    wel_next = 1'b0;
                end else begin
                    cnt_next = cnt_reg - 16'h0001;
                end
            end
            default: st_next = fsbp_pkg::FSBP_IDLE;
        endcase
        if (req_new) begin
            ack_tog_next           = ~ack_tog_reg;
            rsp_core_next.status   = status_byte(lock_reg, tb_reg, bp_reg, wel_reg,
                                                 st_reg == fsbp_pkg::FSBP_BUSY);
            rsp_core_next.accepted = 1'b0;
            rsp_core_next.prot_err = 1'b0;
            if (hold_reg.cmd == fsbp_pkg::FSBP_RDSR) begin
                rsp_core_next.accepted = 1'b1;
            end else if (st_reg == fsbp_pkg::FSBP_IDLE) begin
                case (hold_reg.cmd)
                    fsbp_pkg::FSBP_WREN: begin
                        wel_next               = 1'b1;
                        rsp_core_next.accepted = 1'b1;
                    end
                    fsbp_pkg::FSBP_WRDI: begin
                        wel_next               = 1'b0;
                        rsp_core_next.accepted = 1'b1;
                    end
                    fsbp_pkg::FSBP_WRSR: begin
                        if (wel_reg && !hw_locked) begin
                            lock_next = hold_reg.data[fsbp_pkg::SR_LOCK_BIT];
                            tb_next   = hold_reg.data[fsbp_pkg::SR_TB_BIT];
                            bp_next   = {hold_reg.data[fsbp_pkg::SR_BP_MSB_BIT],
                                hold_reg.data[fsbp_pkg::SR_BP_LOW_HI:fsbp_pkg::SR_BP_LOW_LO]};
                            st_next   = fsbp_pkg::FSBP_BUSY;
                            cnt_next  = 16'(WRSR_CYCLES - 1);
                            rsp_core_next.accepted = 1'b1;
                        end
                    end
                    fsbp_pkg::FSBP_WRNVCR: begin
                        if (wel_reg) begin
                            st_next  = fsbp_pkg::FSBP_BUSY;
                            cnt_next = 16'(WRSR_CYCLES - 1);
                            rsp_core_next.accepted = 1'b1;
                        end
                    end
                    fsbp_pkg::FSBP_PROG, fsbp_pkg::FSBP_SE64,
                    fsbp_pkg::FSBP_SE32, fsbp_pkg::FSBP_SE4: begin
                        if (wel_reg && prot_hit) begin
                            rsp_core_next.prot_err = 1'b1;
                        end else if (wel_reg) begin
                            st_next    = fsbp_pkg::FSBP_BUSY;
                            cnt_next   = (hold_reg.cmd == fsbp_pkg::FSBP_PROG) ?
                                         16'(PROG_CYCLES - 1) : 16'(ERASE_CYCLES - 1);
                            start_next = 1'b1;
                            code_next  = hold_reg.cmd;
                            case (hold_reg.cmd)
                                fsbp_pkg::FSBP_SE64:
                                    addr_next = align(hold_reg.addr, fsbp_pkg::SECTOR_LSB);
                                fsbp_pkg::FSBP_SE32:
                                    addr_next = align(hold_reg.addr, fsbp_pkg::SUB32_LSB);
                                fsbp_pkg::FSBP_SE4:
                                    addr_next = align(hold_reg.addr, fsbp_pkg::SUB4_LSB);
                                default:
                                    addr_next = hold_reg.addr;
                            endcase
                            rsp_core_next.accepted = 1'b1;
                        end
                    end
                    fsbp_pkg::FSBP_BULK: begin
                        if (wel_reg && bp_reg != fsbp_pkg::BP_NONE) begin
                            rsp_core_next.prot_err = 1'b1;
                        end else if (wel_reg) begin
                            st_next    = fsbp_pkg::FSBP_BUSY;
                            cnt_next   = 16'(BULK_CYCLES - 1);
                            start_next = 1'b1;
                            code_next  = fsbp_pkg::FSBP_BULK;
                            addr_next  = 25'h0000000;
                            rsp_core_next.accepted = 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            st_reg       <= fsbp_pkg::FSBP_IDLE;
            cnt_reg      <= 16'h0000;
            lock_reg     <= 1'b0;
            tb_reg       <= 1'b0;
            bp_reg       <= 4'h0;
            wel_reg      <= 1'b0;
            wip_reg      <= 1'b0;
            ready_f_reg  <= 1'b1;
            ack_tog_reg  <= 1'b0;
            rsp_core_reg <= '0;
            sr_reg       <= 8'h00;
            start_reg    <= 1'b0;
            code_reg     <= fsbp_pkg::FSBP_NOP;
            addr_reg     <= 25'h0000000;
        end else begin
            st_reg       <= st_next;
            cnt_reg      <= cnt_next;
            lock_reg     <= lock_next;
            tb_reg       <= tb_next;
            bp_reg       <= bp_next;
            wel_reg      <= wel_next;
            wip_reg      <= st_next == fsbp_pkg::FSBP_BUSY;
            ready_f_reg  <= st_next != fsbp_pkg::FSBP_BUSY;
            ack_tog_reg  <= ack_tog_next;
            rsp_core_reg <= rsp_core_next;
            sr_reg       <= status_byte(lock_next, tb_next, bp_next, wel_next,
                                        st_next == fsbp_pkg::FSBP_BUSY);
            start_reg    <= start_next;
            code_reg     <= code_next;
            addr_reg     <= addr_next;
        end
    end

    assign status_out     = sr_reg;
    assign flag_ready_out = ready_f_reg;
    assign op_start_out   = start_reg;
    assign op_code_out    = code_reg;
    assign op_addr_out    = addr_reg;

    // =====================================================
    // checks
    chk_wrsr_hw_lock: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (req_new && hold_reg.cmd == fsbp_pkg::FSBP_WRSR && hw_locked)
        |=> $stable({lock_reg, tb_reg, bp_reg}) && !rsp_core_reg.accepted)
        else $error("status write taken while hardware locked");

    chk_lock_holds: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (lock_reg && !wp_level_reg) |=> lock_reg)
        else $error("lock bit left while write-protect low");

    chk_status_layout: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        ##1 status_out[fsbp_pkg::SR_LOCK_BIT] == $past(lock_next)
        && status_out[fsbp_pkg::SR_TB_BIT] == tb_reg
        && status_out[fsbp_pkg::SR_BP_MSB_BIT] == bp_reg[3])
        else $error("status byte does not show control bits");

    chk_wel_after_reset: assert property (@(posedge clock_in)
        $rose(reset_n_in) |-> !status_out[fsbp_pkg::SR_WEL_BIT])
        else $error("write enable latch set after reset");

    chk_busy_ends: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        $rose(wip_reg) |-> ##[1:1000] !wip_reg)
        else $error("busy never ends");

    chk_ready_inverse: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        flag_ready_out == !status_out[fsbp_pkg::SR_WIP_BIT])
        else $error("ready flag not inverse of busy bit");

    chk_bulk_guard: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (op_start_out && op_code_out == fsbp_pkg::FSBP_BULK) |-> bp_reg == fsbp_pkg::BP_NONE)
        else $error("bulk erase started with protection set");

    chk_protect_refuse: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (req_new && !wip_reg && wel_reg && prot_hit && hold_reg.cmd == fsbp_pkg::FSBP_PROG)
        |=> !op_start_out && rsp_core_reg.prot_err)
        else $error("program started in protected area");

    chk_top_end: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (!tb_reg && bp_reg != fsbp_pkg::BP_NONE && hold_reg.addr[24:16] == 9'h1ff) |-> prot_hit)
        else $error("top sector not protected");

    chk_bottom_end: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (tb_reg && bp_reg != fsbp_pkg::BP_NONE && hold_reg.addr[24:16] == 9'h000) |-> prot_hit)
        else $error("bottom sector not protected");

    chk_sector_align: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (op_start_out && op_code_out == fsbp_pkg::FSBP_SE64) |-> op_addr_out[15:0] == 16'h0000)
        else $error("sector erase address not aligned");

    chk_wel_cleared: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        $fell(wip_reg) |-> !wel_reg)
        else $error("write enable latch survives cycle end");
endmodule

// [tb/fsbp_host_model.sv]
// host side of the link: one request at a time, answer captured
// assumes the bench holds go_in high until done_out rises, then drops it
`timescale 1ns/10ps
module fsbp_host_model (
    input  wire logic                link_clk_in,
    input  wire logic                go_in,
    input  wire fsbp_pkg::fsbp_req_t req_in,
    input  wire logic                ready_in,
    input  wire logic                rsp_valid_in,
    input  wire fsbp_pkg::fsbp_rsp_t rsp_in,
    output logic                     valid_out,
    output fsbp_pkg::fsbp_req_t      cmd_out,
    output fsbp_pkg::fsbp_rsp_t      rsp_out,
    output logic                     done_out
);
    logic [1:0] st_reg = 2'd0;
    initial begin
        valid_out = 1'b0;
        cmd_out = '0;
        rsp_out = '0;
        done_out = 1'b0;
    end
    // =====================================================
    // request, hold until taken, wait for answer
    always @(posedge link_clk_in) begin
        case (st_reg)
            2'd0: if (go_in && ready_in) begin
                valid_out <= 1'b1;
                cmd_out   <= req_in;
                st_reg    <= 2'd1;
            end else begin
                cmd_out <= ~cmd_out; // released lines keep moving
            end
            2'd1: if (ready_in) begin
                valid_out <= 1'b0;
                cmd_out   <= ~cmd_out;
                st_reg    <= 2'd2;
            end
            2'd2: if (rsp_valid_in) begin
                rsp_out  <= rsp_in;
                done_out <= 1'b1;
                st_reg   <= 2'd3;
            end
            default: if (!go_in) begin
                done_out <= 1'b0;
                st_reg   <= 2'd0;
            end
        endcase
    end
endmodule

// [tb/tb_fsbp_status_ctrl.sv]
// bench of the status register and block protection logic
// assumes the host model on the link and lengthened busy lengths
`timescale 1ns/10ps
module tb_fsbp_status_ctrl;
    logic                clock_in;
    logic                link_clk_in;
    logic                reset_n_in;
    logic                wp_n;
    logic                go;
    fsbp_pkg::fsbp_req_t req;
    logic                cmd_valid;
    fsbp_pkg::fsbp_req_t cmd;
    logic                cmd_ready;
    logic                rsp_valid;
    fsbp_pkg::fsbp_rsp_t rsp;
    fsbp_pkg::fsbp_rsp_t got;
    logic [7:0]          status;
    logic                flag_ready;
    logic                done;
    fsbp_pkg::fsbp_cmd_t op_code;
    logic [24:0]         op_addr;
    logic                op_start;
    int                  n_starts = 0;
    int                  n_errors;
    int                  n_compared;
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    initial begin
        link_clk_in = 1'b0;
        #37;
        forever #80 link_clk_in = ~link_clk_in;
    end
    fsbp_status_ctrl #(.WRSR_CYCLES(400), .PROG_CYCLES(300), .ERASE_CYCLES(300),
        .BULK_CYCLES(300)) i_fsbp_status_ctrl (.clock_in(clock_in), .reset_n_in(reset_n_in),
        .link_clk_in(link_clk_in), .write_protect_n_in(wp_n), .cmd_valid_in(cmd_valid),
        .cmd_in(cmd), .cmd_ready_out(cmd_ready), .rsp_valid_out(rsp_valid), .rsp_out(rsp),
        .status_out(status), .flag_ready_out(flag_ready), .op_start_out(op_start),
        .op_code_out(op_code), .op_addr_out(op_addr));
    fsbp_host_model i_fsbp_host_model (.link_clk_in(link_clk_in), .go_in(go), .req_in(req),
        .ready_in(cmd_ready), .rsp_valid_in(rsp_valid), .rsp_in(rsp), .valid_out(cmd_valid),
        .cmd_out(cmd), .rsp_out(got), .done_out(done));
    // counts start pulses of program and erase
    always @(posedge clock_in) begin
        if (op_start === 1'b1)
            n_starts <= n_starts + 1;
    end
    // =====================================================
    // tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("compared %0d mismatched %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic waitv(ref logic s, input logic v);
        int k;
        k = 0;
        while (s !== v) begin
            @(posedge clock_in);
            k++;
            if (k > 2000) begin
                n_errors++;
                $display("BAD %0t wait ran out", $time);
                summarize();
            end
        end
    endtask
    task automatic send(input fsbp_pkg::fsbp_cmd_t c, input logic [24:0] a,
                        input logic [7:0] d);
        req <= '{cmd: c, addr: a, data: d};
        go  <= 1'b1;
        waitv(done, 1'b1);
        go <= 1'b0;
        waitv(done, 1'b0);
    endtask
    // e is {accepted, prot_err}; a protection refusal compares prot_err only
    task automatic op(input fsbp_pkg::fsbp_cmd_t c, input logic [24:0] a,
                      input logic [7:0] d, input logic [1:0] e);
        send(c, a, d);
        if (e[0])
            chk(got.prot_err, 1'b1);
        else
            chk({got.accepted, got.prot_err}, e);
        waitv(flag_ready, 1'b1);
    endtask
    task automatic wren;
        op(fsbp_pkg::FSBP_WREN, '0, '0, 2'b10);
    endtask
    // =====================================================
    // main sequence
    initial begin
        n_errors = 0;
        n_compared = 0;
        reset_n_in = 1'b0;
        wp_n = 1'b1;
        go = 1'b0;
        req = '0;
        repeat (70) @(posedge clock_in);
        reset_n_in <= 1'b1;
        @(posedge clock_in);
        chk(status, 8'h00);
        chk(flag_ready, 1'b1);
        op(fsbp_pkg::FSBP_WRSR, '0, 8'h84, 2'b00);
        wren();
        chk(status[1], 1'b1);
        send(fsbp_pkg::FSBP_WRSR, '0, 8'h84);
        chk(got.accepted, 1'b1);
        chk(status[0], 1'b1);
        chk(flag_ready, 1'b0);
        waitv(flag_ready, 1'b1);
        chk(status, 8'h84);
        $display("test status write done");
        wp_n <= 1'b0;
        wren();
        op(fsbp_pkg::FSBP_WRSR, '0, 8'h00, 2'b00);
        chk(status, 8'h86);
        wp_n <= 1'b1;
        repeat (4) @(posedge clock_in);
        op(fsbp_pkg::FSBP_WRSR, '0, 8'h04, 2'b10);
        chk(status, 8'h04);
        $display("test hardware lock done");
        wren();
        op(fsbp_pkg::FSBP_PROG, 25'h1ff0000, 8'h5a, 2'b01);
        op(fsbp_pkg::FSBP_PROG, 25'h1fe0123, 8'h5a, 2'b10);
        chk(op_code, fsbp_pkg::FSBP_PROG);
        chk(op_addr[24:16], 9'h1fe);
        chk(status[1], 1'b0);
        wren();
        op(fsbp_pkg::FSBP_BULK, '0, '0, 2'b01);
        op(fsbp_pkg::FSBP_WRSR, '0, 8'h64, 2'b10);
        wren();
        op(fsbp_pkg::FSBP_SE64, 25'h0ff0000, '0, 2'b01);
        op(fsbp_pkg::FSBP_SE64, 25'h1000000, '0, 2'b10);
        $display("test protected area done");
        wren();
        op(fsbp_pkg::FSBP_WRSR, '0, 8'h20, 2'b10);
        wren();
        op(fsbp_pkg::FSBP_BULK, '0, '0, 2'b10);
        op(fsbp_pkg::FSBP_BULK, '0, '0, 2'b00);
        $display("test bulk erase done");
        wren();
        op(fsbp_pkg::FSBP_WRDI, '0, '0, 2'b10);
        chk(status[1], 1'b0);
        op(fsbp_pkg::FSBP_WRNVCR, '0, '0, 2'b00);
        wren();
        send(fsbp_pkg::FSBP_WRNVCR, '0, 8'h00);
        chk(got.accepted, 1'b1);
        chk(status[0], 1'b1);
        waitv(flag_ready, 1'b1);
        wren();
        op(fsbp_pkg::FSBP_SE32, 25'h1234567, '0, 2'b10);
        chk(op_addr, 25'h1230000);
        wren();
        op(fsbp_pkg::FSBP_SE4, 25'h1234567, '0, 2'b10);
        chk(op_addr, 25'h1234000);
        op(fsbp_pkg::FSBP_RDSR, '0, '0, 2'b10);
        chk(got.status, 8'h20);
        chk(n_starts, 5);
        $display("test other commands done");
        summarize();
    end
endmodule
